/* hdl/flkg_cfg.svh */
// Constants of the flash lock and key guard: offsets, key codes, state codes
`ifndef FLKG_CFG_SVH
`define FLKG_CFG_SVH
`define FLKG_OFF_KEY 12'h000
`define FLKG_OFF_CTRL 12'h004
`define FLKG_OFF_STAT 12'h008
`define FLKG_KEY1 8'ha5
`define FLKG_KEY2 8'hf1
`define FLKG_CODE_LOCKED 2'h0
`define FLKG_CODE_FIRST 2'h1
`define FLKG_CODE_OPEN 2'h2
`define FLKG_CODE_DEAD 2'h3
`define FLKG_RESP_OKAY 2'h0
`define FLKG_RESP_SLVERR 2'h2
`define FLKG_CTRL_WE 0
`define FLKG_CTRL_EE 1
`define FLKG_ERASED 8'hff
`define FLKG_KEY_RST 8'h00
`endif

/* hdl/flkg_pkg.sv */
// Types of the flash lock and key guard
package flkg_pkg;
   // Key sequence tracker states
   typedef enum logic [1:0] {FLKG_LOCKED, FLKG_FIRST, FLKG_OPEN, FLKG_DEAD} flkg_state_t;
   // Flash modify request from the core
   typedef struct packed {
      logic erase;
      logic [15:0] addr;
      logic [7:0] data;
   } flkg_req_t;
   // Command passed on to the flash controller
   typedef struct packed {
      logic erase;
      logic [15:0] addr;
      logic [7:0] data;
   } flkg_cmd_t;
endpackage : flkg_pkg

/* hdl/flkg_guard.sv */
// Flash lock and key guard with AXI4-Lite register slave
//******************************************************************
// How it works
// - A5 then F1 arms flash modify
// - Launching an operation withdraws the enable
// - Wrong key write locks until reset
// - Permitted modify while disarmed and not busy locks until reset
// - Key register read gives state bits
// - 00 locked, 01 first key taken
// - 10 while modify is enabled
// - 11 after violation, kept until reset
// - Write needs WE, erase WE and EE
// - Write only clears bits; erase sets
//******************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "flkg_cfg.svh"
module flkg_guard
   import flkg_pkg::*;
#(
   parameter int ADDR_W = 12
)(
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core side modify request (one-cycle pulse, same clock)
   input wire logic req_valid,
   input wire flkg_req_t req,
   input wire logic [7:0] old_byte,
   // Flash controller side
   output flkg_cmd_t cmd,
   output logic cmd_valid,
   input wire logic cmd_done,
   output logic refused
);

   //******************************************************************
   // Register slave
   //******************************************************************
   logic aw_ok_ff, w_ok_ff; // Address / data captured
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [7:0] key_ff; // Last key byte written
   logic we_ff, ee_ff; // Program store write / erase enables
   flkg_state_t state_ff, nxt_state;
   flkg_cmd_t cmd_ff;
   logic cmd_valid_ff, busy_ff, refused_ff;

   // Word offset compare, low two bits ignored
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(off >> 2));
   endfunction : hit

   // Write happens once both halves are present and no response is pending
   wire wr_go = aw_ok_ff && w_ok_ff && !bvalid_ff;
   wire wr_key = wr_go && hit(awaddr_ff, `FLKG_OFF_KEY) && wstrb_ff[0];
   wire wr_ctrl = wr_go && hit(awaddr_ff, `FLKG_OFF_CTRL) && wstrb_ff[0];
   wire wr_map = hit(awaddr_ff, `FLKG_OFF_KEY) || hit(awaddr_ff, `FLKG_OFF_CTRL) ||
                 hit(awaddr_ff, `FLKG_OFF_STAT);
   wire [7:0] wbyte = wdata_ff[7:0];
   wire rd_go = s_axi_arvalid && arready_ff;
   wire rd_key = hit(s_axi_araddr, `FLKG_OFF_KEY);
   wire rd_ctrl = hit(s_axi_araddr, `FLKG_OFF_CTRL);
   wire rd_stat = hit(s_axi_araddr, `FLKG_OFF_STAT);
   wire [1:0] code = state_ff; // Enum order equals lock code
   // Read mux: key register shows lock code in bits 1:0
   wire [31:0] rd_val = rd_key ? {30'h0, code} :
                        rd_ctrl ? {30'h0, ee_ff, we_ff} :
                        rd_stat ? {23'h0, key_ff, 1'b0} : 32'h0;

   // Write channel handshakes, address and data in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ok_ff <= 1'b0;
         w_ok_ff <= 1'b0;
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= `FLKG_RESP_OKAY;
         awaddr_ff <= '0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && awready_ff)
         begin
            aw_ok_ff <= 1'b1;
            awready_ff <= 1'b0;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_ff)
         begin
            w_ok_ff <= 1'b1;
            wready_ff <= 1'b0;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            // Response one cycle after both halves are in
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_map ? `FLKG_RESP_OKAY : `FLKG_RESP_SLVERR;
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
         end
         if (bvalid_ff && s_axi_bready)
         begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
      end
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= `FLKG_RESP_OKAY;
      end
      else if (rd_go)
      begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_val;
         rresp_ff <= (rd_key || rd_ctrl || rd_stat) ? `FLKG_RESP_OKAY : `FLKG_RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
      begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   //******************************************************************
   // Program store control and key byte
   //******************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         we_ff <= 1'b0;
         ee_ff <= 1'b0;
         key_ff <= `FLKG_KEY_RST; // Zero out of reset
      end
      else
      begin
         if (wr_ctrl)
         begin
            we_ff <= wbyte[`FLKG_CTRL_WE];
            ee_ff <= wbyte[`FLKG_CTRL_EE];
         end
         if (wr_key)
            key_ff <= wbyte;
      end
   end

   //******************************************************************
   // Key sequence tracker
   //******************************************************************
   // Permission from the program store enables
   wire perm = req.erase ? (we_ff && ee_ff) : we_ff;
   // A modify attempt only counts when enables permit it; else it is an ordinary data write
   wire attempt = req_valid && perm && !busy_ff;
   wire launch = attempt && (state_ff == FLKG_OPEN);

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         FLKG_LOCKED:
            if (attempt)
               nxt_state = FLKG_DEAD; // Disarmed modify
            else if (wr_key)
               nxt_state = (wbyte == `FLKG_KEY1) ? FLKG_FIRST : FLKG_DEAD;
         FLKG_FIRST:
            if (attempt)
               nxt_state = FLKG_DEAD;
            else if (wr_key)
               nxt_state = (wbyte == `FLKG_KEY2) ? FLKG_OPEN : FLKG_DEAD;
         FLKG_OPEN:
            if (launch)
               nxt_state = FLKG_LOCKED; // One operation per key pair
            else if (wr_key)
               nxt_state = FLKG_DEAD; // Extra key write is out of sequence
         FLKG_DEAD:
            nxt_state = FLKG_DEAD; // Only reset leaves here
      endcase
   end

   // Enable is withdrawn at launch, so no second request can slip in while busy
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_ff <= FLKG_LOCKED;
      else
         state_ff <= nxt_state;
   end

   //******************************************************************
   // Flash command issue
   //******************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmd_ff <= '0;
         cmd_valid_ff <= 1'b0;
         busy_ff <= 1'b0;
         refused_ff <= 1'b0;
      end
      else
      begin
         cmd_valid_ff <= launch;
         refused_ff <= req_valid && !launch;
         if (launch)
         begin
            busy_ff <= 1'b1;
            cmd_ff.erase <= req.erase;
            cmd_ff.addr <= req.addr;
            // Writes can only clear bits
            cmd_ff.data <= req.erase ? `FLKG_ERASED : (req.data & old_byte);
         end
         else if (cmd_done)
            busy_ff <= 1'b0;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign cmd = cmd_ff;
   assign cmd_valid = cmd_valid_ff;
   assign refused = refused_ff;

   //******************************************************************
   // Checks
   //******************************************************************
   property p_key_pair;
      @(posedge aclk) disable iff (!aresetn)
      (state_ff == FLKG_FIRST && wr_key && wbyte == `FLKG_KEY2 && !attempt) |=> state_ff == FLKG_OPEN;
   endproperty
   a_key_pair: assert property (p_key_pair) else $error("second key did not open");

   property p_one_shot;
      @(posedge aclk) disable iff (!aresetn)
      launch |=> state_ff == FLKG_LOCKED ##1 !cmd_valid_ff;
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("enable kept after launch");

   property p_bad_key;
      @(posedge aclk) disable iff (!aresetn)
      (wr_key && !attempt && state_ff == FLKG_LOCKED && wbyte != `FLKG_KEY1) |=> state_ff == FLKG_DEAD;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("wrong key did not lock");

   property p_disarmed;
      @(posedge aclk) disable iff (!aresetn)
      (attempt && state_ff != FLKG_OPEN) |=> state_ff == FLKG_DEAD ##1 !cmd_valid_ff;
   endproperty
   a_disarmed: assert property (p_disarmed) else $error("disarmed modify not locked");

   property p_read_code;
      @(posedge aclk) disable iff (!aresetn)
      (rd_go && rd_key) |=> s_axi_rdata == {30'h0, $past(code)};
   endproperty
   a_read_code: assert property (p_read_code) else $error("key read wrong code");

   property p_first_code;
      @(posedge aclk) disable iff (!aresetn)
      (state_ff == FLKG_LOCKED && wr_key && wbyte == `FLKG_KEY1 && !attempt) |=> code == `FLKG_CODE_FIRST;
   endproperty
   a_first_code: assert property (p_first_code) else $error("first key code not 01");

   property p_open_perm;
      @(posedge aclk) disable iff (!aresetn)
      cmd_valid_ff |-> $past(code) == `FLKG_CODE_OPEN && $past(perm);
   endproperty
   a_open_perm: assert property (p_open_perm) else $error("command without key or enable");

   property p_dead_sticks;
      @(posedge aclk) disable iff (!aresetn)
      code == `FLKG_CODE_DEAD |=> code == `FLKG_CODE_DEAD && !cmd_valid_ff;
   endproperty
   a_dead_sticks: assert property (p_dead_sticks) else $error("lock left before reset");

   property p_clear_only;
      @(posedge aclk) disable iff (!aresetn)
      (launch && !req.erase) |=> (cmd_ff.data & ~$past(old_byte)) == 8'h00;
   endproperty
   a_clear_only: assert property (p_clear_only) else $error("write set a bit");

endmodule : flkg_guard
`default_nettype wire

/* dv/flkg_guard_tb_top.sv */
// Self-checking testbench of the flash lock and key guard
`timescale 1ns/1ps
`default_nettype none
`include "flkg_cfg.svh"
module flkg_guard_tb_top
   import flkg_pkg::*;
;
   //******************************************************************
   // Signals
   //******************************************************************
   logic aclk; // 125 MHz system clock
   logic aresetn; // Synchronous, active low
   logic [11:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic req_valid; // Core modify attempt
   flkg_req_t req;
   logic [7:0] old_byte; // Current flash byte
   flkg_cmd_t cmd; // To flash controller
   logic cmd_valid, cmd_done, refused;
   logic [31:0] rnd; // Stimulus generator state
   logic [33:0] exp_rd[$]; // Expected {rresp, rdata}
   logic [1:0] exp_b[$]; // Expected write response
   logic [25:0] exp_fl[$]; // Expected {refused, cmd}
   int miscompares;
   int checked;
   //******************************************************************
   // Device under test
   //******************************************************************
   flkg_guard #(.ADDR_W(12)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .req_valid(req_valid), .req(req), .old_byte(old_byte),
      .cmd(cmd), .cmd_valid(cmd_valid), .cmd_done(cmd_done), .refused(refused));
   //******************************************************************
   // Helpers
   //******************************************************************
   // Galois-free shift register step, fixed seed keeps runs repeatable
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Compare and count
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Verdict and end of run
   task automatic close_out;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   // Reset held ten cycles, also usable mid-run
   task automatic rst;
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : rst
   // Bus write; upper data bits random since only byte 0 counts
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      exp_b.push_back(r);
      rnd = lfsr(rnd);
      awaddr <= a;
      wdata <= {rnd[31:8], d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (!bvalid);
      bready <= 1'b0;
      // Idle edge so a following call never reassigns bready in this step
      @(posedge aclk);
   endtask : wr
   // Bus read, result judged by the monitor
   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      exp_rd.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      while (!rvalid);
      rready <= 1'b0;
      // Idle edge so a following call never reassigns rready in this step
      @(posedge aclk);
   endtask : rd
   // Flash modify attempt; go tells whether it must launch
   task automatic fl(input logic er, input logic go);
      flkg_req_t r;
      rnd = lfsr(rnd);
      r.erase = er;
      r.addr = rnd[31:16];
      r.data = rnd[7:0];
      exp_fl.push_back({~go, er, r.addr, er ? `FLKG_ERASED : (r.data & rnd[15:8])});
      req <= r;
      old_byte <= rnd[15:8];
      req_valid <= 1'b1;
      @(posedge aclk);
      req_valid <= 1'b0;
      repeat (2) @(posedge aclk);
      // Controller reports completion so busy clears
      if (go)
      begin
         cmd_done <= 1'b1;
         @(posedge aclk);
         cmd_done <= 1'b0;
      end
   endtask : fl
   //******************************************************************
   // Clock, watchdog and monitor
   //******************************************************************
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // Whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge aclk);
      miscompares++;
      close_out();
   end
   // Oldest note is taken off whenever a result shows
   always @(posedge aclk)
   begin
      logic [25:0] e;
      if (rvalid && rready) chk("rdata", exp_rd.pop_front(), {rresp, rdata});
      if (bvalid && bready) chk("bresp", 34'(exp_b.pop_front()), 34'(bresp));
      if (cmd_valid || refused)
      begin
         e = exp_fl.pop_front();
         chk("refused", 34'(e[25]), 34'(refused));
         // Command content only matters on a launch
         if (!e[25]) chk("cmd", 34'(e[24:0]), 34'(cmd));
      end
   end
   //******************************************************************
   // Scenarios
   //******************************************************************
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid, cmd_done} = '0;
      {awaddr, araddr, wdata, wstrb, req, old_byte} = '0;
      wstrb = 4'hf;
      rnd = 32'he73f021f;
      rst();
      rd(`FLKG_OFF_KEY, 34'h0);
      rd(12'h00c, {`FLKG_RESP_SLVERR, 32'h0});
      wr(12'h010, 8'h5a, `FLKG_RESP_SLVERR);
      // One write then one erase, rekeyed each time
      for (int k = 0; k < 2; k++)
      begin
         wr(`FLKG_OFF_CTRL, k ? 8'h03 : 8'h01, `FLKG_RESP_OKAY);
         rd(`FLKG_OFF_CTRL, k ? 34'h3 : 34'h1);
         wr(`FLKG_OFF_KEY, `FLKG_KEY1, `FLKG_RESP_OKAY);
         rd(`FLKG_OFF_KEY, 34'h1);
         rd(`FLKG_OFF_STAT, {`FLKG_RESP_OKAY, 23'h0, `FLKG_KEY1, 1'b0});
         wr(`FLKG_OFF_KEY, `FLKG_KEY2, `FLKG_RESP_OKAY);
         rd(`FLKG_OFF_KEY, 34'h2);
         fl(k[0], 1'b1);
         rd(`FLKG_OFF_KEY, 34'h0);
      end
      // No enables: plain data write, refused without lock
      wr(`FLKG_OFF_CTRL, 8'h00, `FLKG_RESP_OKAY);
      fl(1'b0, 1'b0);
      rd(`FLKG_OFF_KEY, 34'h0);
      // Write enable alone does not permit an erase
      wr(`FLKG_OFF_CTRL, 8'h01, `FLKG_RESP_OKAY);
      fl(1'b1, 1'b0);
      rd(`FLKG_OFF_KEY, 34'h0);
      // Wrong second key locks for good, fresh keys do not help
      wr(`FLKG_OFF_KEY, `FLKG_KEY1, `FLKG_RESP_OKAY);
      wr(`FLKG_OFF_KEY, 8'h00, `FLKG_RESP_OKAY);
      rd(`FLKG_OFF_KEY, 34'h3);
      wr(`FLKG_OFF_KEY, `FLKG_KEY1, `FLKG_RESP_OKAY);
      wr(`FLKG_OFF_KEY, `FLKG_KEY2, `FLKG_RESP_OKAY);
      wr(`FLKG_OFF_CTRL, 8'h01, `FLKG_RESP_OKAY);
      fl(1'b0, 1'b0);
      rd(`FLKG_OFF_KEY, 34'h3);
      // Reset clears the lock; attempt while disarmed locks
      rst();
      rd(`FLKG_OFF_KEY, 34'h0);
      // Key write with byte lane 0 off has no effect
      wstrb <= 4'he;
      wr(`FLKG_OFF_KEY, 8'h00, `FLKG_RESP_OKAY);
      wstrb <= 4'hf;
      rd(`FLKG_OFF_KEY, 34'h0);
      wr(`FLKG_OFF_CTRL, 8'h01, `FLKG_RESP_OKAY);
      fl(1'b0, 1'b0);
      rd(`FLKG_OFF_KEY, 34'h3);
      // Second key first is out of order
      rst();
      wr(`FLKG_OFF_KEY, `FLKG_KEY2, `FLKG_RESP_OKAY);
      rd(`FLKG_OFF_KEY, 34'h3);
      // Any key write while open also locks
      rst();
      wr(`FLKG_OFF_KEY, `FLKG_KEY1, `FLKG_RESP_OKAY);
      wr(`FLKG_OFF_KEY, `FLKG_KEY2, `FLKG_RESP_OKAY);
      wr(`FLKG_OFF_KEY, `FLKG_KEY1, `FLKG_RESP_OKAY);
      rd(`FLKG_OFF_KEY, 34'h3);
      repeat (3) @(posedge aclk);
      chk("pending", 34'h0, 34'(exp_rd.size() + exp_b.size() + exp_fl.size()));
      close_out();
   end
endmodule : flkg_guard_tb_top
`default_nettype wire
